// *** src/mir_defines.vh ***
// register indices, field layouts and reset values of the interrupt router
`ifndef MIR_DEFINES_VH
`define MIR_DEFINES_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define MIR_IDX_STS1 8'h10
`define MIR_IDX_STS2 8'h11
`define MIR_IDX_STS3 8'h12
`define MIR_IDX_STS4 8'h13
`define MIR_IDX_STS5 8'h14
`define MIR_IDX_GAP0 8'h15
`define MIR_IDX_EN1 8'h16
`define MIR_IDX_EN2 8'h17
`define MIR_IDX_EN3 8'h18
`define MIR_IDX_EN4 8'h19
`define MIR_IDX_EN5 8'h1a
`define MIR_IDX_GAPA 8'h1b
`define MIR_IDX_MSC 8'h1c
`define MIR_IDX_GAPB 8'h1d
`define MIR_IDX_ISTS 8'h30
`define MIR_IDX_ICLR 8'h31
`define MIR_IDX_IEN 8'h32

// ----------------------------------------
// writable / implemented bit masks
// ----------------------------------------
`define MIR_MASK_EN1 8'h3e
`define MIR_MASK_EN2 8'hf7
`define MIR_MASK_EN3 8'hf7
`define MIR_MASK_EN4 8'hff
`define MIR_MASK_EN5 8'hcf
`define MIR_MASK_STS2 8'h17
`define MIR_MASK_MSC 8'h3f
`define MIR_MASK_IRQ 3'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define MIR_BIT_IR 2
`define MIR_BIT_PME 5
`define MIR_BIT_SER 6
`define MIR_BIT_PIN 7
`define MIR_EV_GROUP 0
`define MIR_EV_EDGE 1
`define MIR_EV_IR 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define MIR_RST_REG 8'h00
`define MIR_RST_IRQ 3'h0

`endif

// *** src/mir_edge_detect.v ***
// either-edge detector for synchronous pin levels
`default_nettype none

module mir_edge_detect #(
    parameter WIDTH = 6
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] edge_pulse
);

// ----------------------------------------
// history
// ----------------------------------------
// first cycle after reset only loads history, so a pin that sits
// high through reset does not look like an edge
reg primed_ff;
reg [WIDTH-1:0] prev_ff;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        primed_ff <= 1'b0;
        prev_ff <= {WIDTH{1'b0}};
    end else begin
        primed_ff <= 1'b1;
        prev_ff <= pin_in;
    end
end

assign edge_pulse = {WIDTH{primed_ff}} & (pin_in ^ prev_ff);

endmodule // mir_edge_detect

`default_nettype wire

// *** src/mir_top.v ***
// management interrupt enable router with apb register access
//
// Behaviour
// - enable reg one gates peripheral sources
// - enable reg two gates mouse/keyboard/infrared/kbc
// - route bit five feeds power-event logic
// - route bit six feeds serial irq
// - route bit seven drives dedicated pin
// - enable reg three gates gpio group a
// - enable reg four gates gpio group b
// - enable reg five gates gpio/fan tach
// - gaps 1b, 1d read zero, ignore writes
// - edge status bits clear on written one
// - pin edges set sticky edge status bits
// - edge status bits seven, six read zero
// - gpio/fan status clears on written one
// - infrared status set by edge, read-clear
`default_nettype none
`include "mir_defines.vh"

module mir_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [4:0] periph_irq,
    input wire mouse_irq,
    input wire keyboard_irq,
    input wire kbc_port_line,
    input wire infrared_rx,
    input wire [7:0] gpio_event_a,
    input wire [7:0] gpio_event_b,
    input wire [3:0] gpio_event_c,
    input wire fan_tacho_in_one,
    input wire fan_tacho_in_two,
    input wire gpio_pin_2_1,
    input wire gpio_pin_2_2,
    input wire gpio_pin_4_1,
    input wire gpio_pin_4_3,
    input wire gpio_pin_6_0,
    input wire gpio_pin_6_1,
    output wire group_mgmt_irq_n,
    output wire mgmt_irq_out_pin,
    output wire mgmt_irq_out_oe,
    output wire serial_irq_group,
    output wire power_event_logic,
    output wire irq
);

// ----------------------------------------
// state
// ----------------------------------------
reg [31:0] prdata_ff;
reg pready_ff;
reg pslverr_ff;
reg [7:0] en1_ff;
reg [7:0] en2_ff;
reg [7:0] en3_ff;
reg [7:0] en4_ff;
reg [7:0] en5_ff;
reg [7:0] sts3_ff;
reg [7:0] sts4_ff;
reg [7:0] sts5_ff;
reg ir_sts_ff;
reg [5:0] msc_ff;
reg [2:0] irq_sts_ff;
reg [2:0] irq_en_ff;
reg irq_ff;
reg group_n_ff;
reg pin_ff;
reg pin_oe_ff;
reg ser_ff;
reg pme_ff;

reg [31:0] nxt_prdata;
reg nxt_pslverr;
reg [7:0] nxt_sts3;
reg [7:0] nxt_sts4;
reg [7:0] nxt_sts5;
reg nxt_ir_sts;
reg [5:0] nxt_msc;
reg [2:0] nxt_irq_sts;

// ----------------------------------------
// apb decode
// ----------------------------------------
// one wait state: data and error are registered in the first
// access cycle, pready rises in the second
wire addr_ok = (paddr[11:10] == 2'b00) & (paddr[1:0] == 2'b00);
wire access = psel & penable;
wire done = access & pready_ff;
// an errored transfer must not alias onto a register, so no write or read-clear
wire wr_done = done & pwrite & addr_ok;
wire rd_done = done & ~pwrite & addr_ok;
wire [7:0] idx = paddr[9:2];
wire [7:0] wbyte = pwdata[7:0];

wire wr_en1 = wr_done & (idx == `MIR_IDX_EN1);
wire wr_en2 = wr_done & (idx == `MIR_IDX_EN2);
wire wr_en3 = wr_done & (idx == `MIR_IDX_EN3);
wire wr_en4 = wr_done & (idx == `MIR_IDX_EN4);
wire wr_en5 = wr_done & (idx == `MIR_IDX_EN5);
wire wr_sts3 = wr_done & (idx == `MIR_IDX_STS3);
wire wr_sts4 = wr_done & (idx == `MIR_IDX_STS4);
wire wr_sts5 = wr_done & (idx == `MIR_IDX_STS5);
wire wr_msc = wr_done & (idx == `MIR_IDX_MSC);
wire wr_iclr = wr_done & (idx == `MIR_IDX_ICLR);
wire wr_ien = wr_done & (idx == `MIR_IDX_IEN);
wire rd_sts2 = rd_done & (idx == `MIR_IDX_STS2);

// ----------------------------------------
// edge detection
// ----------------------------------------
wire [5:0] msc_pins = {gpio_pin_6_1, gpio_pin_6_0, gpio_pin_4_3,
                       gpio_pin_4_1, gpio_pin_2_2, gpio_pin_2_1};
wire [5:0] msc_edge;
wire [0:0] ir_edge;

mir_edge_detect #(
    .WIDTH(6)
) u_msc_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(msc_pins),
    .edge_pulse(msc_edge)
);

mir_edge_detect #(
    .WIDTH(1)
) u_ir_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(infrared_rx),
    .edge_pulse(ir_edge)
);

// ----------------------------------------
// source status views
// ----------------------------------------
// peripheral, mouse, keyboard and kbc sources clear at their source,
// so their status is the live level
wire [7:0] sts1 = {2'b00, periph_irq, 1'b0};
wire [7:0] sts2 = {3'b000, kbc_port_line, 1'b0, ir_sts_ff,
                   keyboard_irq, mouse_irq};
wire [7:0] sts3_set = gpio_event_a & `MIR_MASK_EN3;
wire [7:0] sts4_set = gpio_event_b & `MIR_MASK_EN4;
wire [7:0] sts5_set = {fan_tacho_in_two, fan_tacho_in_one,
                       2'b00, gpio_event_c};

// ----------------------------------------
// sticky status next values (set wins over clear)
// ----------------------------------------
always @* begin
    nxt_sts3 = sts3_ff;
    nxt_sts4 = sts4_ff;
    nxt_sts5 = sts5_ff;
    if (wr_sts3) begin
        nxt_sts3 = sts3_ff & ~wbyte;
    end
    if (wr_sts4) begin
        nxt_sts4 = sts4_ff & ~wbyte;
    end
    if (wr_sts5) begin
        nxt_sts5 = sts5_ff & ~wbyte;
    end
    nxt_sts3 = nxt_sts3 | sts3_set;
    nxt_sts4 = nxt_sts4 | sts4_set;
    nxt_sts5 = nxt_sts5 | sts5_set;
end

always @* begin
    nxt_ir_sts = ir_sts_ff;
    if (rd_sts2) begin
        nxt_ir_sts = 1'b0;
    end
    if (ir_edge[0]) begin
        nxt_ir_sts = 1'b1;
    end
end

always @* begin
    nxt_msc = msc_ff;
    if (wr_msc) begin
        nxt_msc = msc_ff & ~wbyte[5:0];
    end
    nxt_msc = nxt_msc | msc_edge;
end

// ----------------------------------------
// group interrupt
// ----------------------------------------
wire [7:0] hit1 = sts1 & en1_ff & `MIR_MASK_EN1;
wire [7:0] hit2 = sts2 & en2_ff & `MIR_MASK_STS2;
wire [7:0] hit3 = sts3_ff & en3_ff;
wire [7:0] hit4 = sts4_ff & en4_ff;
wire [7:0] hit5 = sts5_ff & en5_ff;
wire pending = |{hit1, hit2, hit3, hit4, hit5};

// ----------------------------------------
// local interrupt status
// ----------------------------------------
wire [2:0] irq_ev;
assign irq_ev[`MIR_EV_GROUP] = pending & group_n_ff;
assign irq_ev[`MIR_EV_EDGE] = |msc_edge;
assign irq_ev[`MIR_EV_IR] = ir_edge[0];

always @* begin
    nxt_irq_sts = irq_sts_ff;
    if (wr_iclr) begin
        nxt_irq_sts = irq_sts_ff & ~wbyte[2:0];
    end
    nxt_irq_sts = nxt_irq_sts | irq_ev;
end

// ----------------------------------------
// read mux
// ----------------------------------------
always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    if (!addr_ok) begin
        nxt_pslverr = 1'b1;
    end else begin
        case (idx)
            `MIR_IDX_STS1: nxt_prdata[7:0] = sts1;
            `MIR_IDX_STS2: nxt_prdata[7:0] = sts2;
            `MIR_IDX_STS3: nxt_prdata[7:0] = sts3_ff;
            `MIR_IDX_STS4: nxt_prdata[7:0] = sts4_ff;
            `MIR_IDX_STS5: nxt_prdata[7:0] = sts5_ff;
            `MIR_IDX_GAP0: nxt_prdata[7:0] = 8'h00;
            `MIR_IDX_EN1: nxt_prdata[7:0] = en1_ff;
            `MIR_IDX_EN2: nxt_prdata[7:0] = en2_ff;
            `MIR_IDX_EN3: nxt_prdata[7:0] = en3_ff;
            `MIR_IDX_EN4: nxt_prdata[7:0] = en4_ff;
            `MIR_IDX_EN5: nxt_prdata[7:0] = en5_ff;
            `MIR_IDX_GAPA: nxt_prdata[7:0] = 8'h00;
            `MIR_IDX_MSC: nxt_prdata[7:0] = {2'b00, msc_ff};
            `MIR_IDX_GAPB: nxt_prdata[7:0] = 8'h00;
            `MIR_IDX_ISTS: nxt_prdata[2:0] = irq_sts_ff;
            `MIR_IDX_ICLR: nxt_prdata[7:0] = 8'h00;
            `MIR_IDX_IEN: nxt_prdata[2:0] = irq_en_ff;
            default: nxt_pslverr = 1'b1;
        endcase
    end
end

// ----------------------------------------
// apb handshake registers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_ff <= 32'h0000_0000;
        pready_ff <= 1'b0;
        pslverr_ff <= 1'b0;
    end else begin
        pready_ff <= access & ~pready_ff;
        if (access & ~pready_ff) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end else begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
    end
end

// ----------------------------------------
// enable registers
// ----------------------------------------
// gap offsets have no write decode, so writes there fall away
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        en1_ff <= `MIR_RST_REG;
        en2_ff <= `MIR_RST_REG;
        en3_ff <= `MIR_RST_REG;
        en4_ff <= `MIR_RST_REG;
        en5_ff <= `MIR_RST_REG;
        irq_en_ff <= `MIR_RST_IRQ;
    end else begin
        if (wr_en1) begin
            en1_ff <= wbyte & `MIR_MASK_EN1;
        end
        if (wr_en2) begin
            en2_ff <= wbyte & `MIR_MASK_EN2;
        end
        if (wr_en3) begin
            en3_ff <= wbyte & `MIR_MASK_EN3;
        end
        if (wr_en4) begin
            en4_ff <= wbyte & `MIR_MASK_EN4;
        end
        if (wr_en5) begin
            en5_ff <= wbyte & `MIR_MASK_EN5;
        end
        if (wr_ien) begin
            irq_en_ff <= wbyte[2:0] & `MIR_MASK_IRQ;
        end
    end
end

// ----------------------------------------
// status registers
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sts3_ff <= `MIR_RST_REG;
        sts4_ff <= `MIR_RST_REG;
        sts5_ff <= `MIR_RST_REG;
        ir_sts_ff <= 1'b0;
        msc_ff <= 6'h00;
        irq_sts_ff <= `MIR_RST_IRQ;
    end else begin
        sts3_ff <= nxt_sts3;
        sts4_ff <= nxt_sts4;
        sts5_ff <= nxt_sts5;
        ir_sts_ff <= nxt_ir_sts;
        msc_ff <= nxt_msc;
        irq_sts_ff <= nxt_irq_sts;
    end
end

// ----------------------------------------
// group routing outputs
// ----------------------------------------
// group outputs lag the status by one cycle, irq is taken from the next status so it does not; every one leaves a flop
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        group_n_ff <= 1'b1;
        pin_ff <= 1'b1;
        pin_oe_ff <= 1'b0;
        ser_ff <= 1'b0;
        pme_ff <= 1'b0;
        irq_ff <= 1'b0;
    end else begin
        group_n_ff <= ~pending;
        pme_ff <= pending & en2_ff[`MIR_BIT_PME];
        ser_ff <= pending & en2_ff[`MIR_BIT_SER];
        pin_oe_ff <= en2_ff[`MIR_BIT_PIN];
        pin_ff <= ~(pending & en2_ff[`MIR_BIT_PIN]);
        irq_ff <= |(nxt_irq_sts & irq_en_ff);
    end
end

// ----------------------------------------
// outputs
// ----------------------------------------
assign prdata = prdata_ff;
assign pready = pready_ff;
assign pslverr = pslverr_ff;
assign group_mgmt_irq_n = group_n_ff;
assign mgmt_irq_out_pin = pin_ff;
assign mgmt_irq_out_oe = pin_oe_ff;
assign serial_irq_group = ser_ff;
assign power_event_logic = pme_ff;
assign irq = irq_ff;

endmodule // mir_top

`default_nettype wire

// *** verification/mir_host_model.sv ***
// far-side model of the shared management pin with its board pull-up
`default_nettype none
module mir_host_model (
    input wire logic pin,
    input wire logic oe,
    output wire logic pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // a released pin floats to the pull-up level, never to the last driven value
    assign pin_level = oe ? pin : 1'b1;
endmodule // mir_host_model
`default_nettype wire

// *** verification/mir_top_monitor.sv ***
// port-level assertions for the management interrupt router
`default_nettype none
module mir_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic group_mgmt_irq_n,
    input wire logic mgmt_irq_out_pin,
    input wire logic mgmt_irq_out_oe,
    input wire logic serial_irq_group,
    input wire logic power_event_logic
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic rd = psel && penable && pready && !pwrite;
    wire logic [7:0] idx = paddr[9:2];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_oe_pin: assert property (mgmt_irq_out_oe |-> mgmt_irq_out_pin == group_mgmt_irq_n)
        else $error("pin differs from group");
    a_pin_idle: assert property (!mgmt_irq_out_oe |-> mgmt_irq_out_pin)
        else $error("released pin active");
    a_serial_grp: assert property (serial_irq_group |-> !group_mgmt_irq_n)
        else $error("serial route without group");
    a_power_grp: assert property (power_event_logic |-> !group_mgmt_irq_n)
        else $error("power route without group");
    a_gap_zero: assert property (rd && (idx == 8'h1b || idx == 8'h1d) |-> prdata == 32'h0)
        else $error("gap read not zero");
    a_msc_top: assert property (rd && idx == 8'h1c |-> prdata[31:6] == 26'h0)
        else $error("edge status top bits set");
    a_en1_rsvd: assert property (rd && idx == 8'h16 |-> (prdata[7:0] & 8'hc1) == 8'h00)
        else $error("enable one reserved bit set");
    a_en2_rsvd: assert property (rd && idx == 8'h17 |-> !prdata[3])
        else $error("enable two reserved bit set");
    a_en5_rsvd: assert property (rd && idx == 8'h1a |-> prdata[5:4] == 2'b00)
        else $error("enable five reserved bits set");
    a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("wait state count wrong");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    c_group: cover property ($fell(group_mgmt_irq_n));
    c_routes: cover property (serial_irq_group && power_event_logic);
    c_error: cover property (pslverr);
endmodule // mir_monitor
bind mir_top mir_monitor u_mir_monitor (.*);
`default_nettype wire

// *** verification/mir_top_test.sv ***
// self-checking bench for the management interrupt router
`default_nettype none
module mir_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ir = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, x, seed = 32'h00014910;
    logic pready, pslverr, gn, opin, oe, sg, pe, irq, pin_lvl, pend;
    logic [29:0] src = 30'h0;
    logic [5:0] gp = 6'h00;
    logic [1:0] hi = 2'b00;
    logic [32:0] q[$];
    int bad_count = 0, n_tests = 0;
    mir_top u_mir_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_irq(src[4:0]), .mouse_irq(src[5]), .keyboard_irq(src[6]), .kbc_port_line(src[7]),
        .infrared_rx(ir), .gpio_event_a(src[15:8]), .gpio_event_b(src[23:16]), .gpio_event_c(src[27:24]),
        .fan_tacho_in_one(src[28]), .fan_tacho_in_two(src[29]), .gpio_pin_2_1(gp[0]), .gpio_pin_2_2(gp[1]),
        .gpio_pin_4_1(gp[2]), .gpio_pin_4_3(gp[3]), .gpio_pin_6_0(gp[4]), .gpio_pin_6_1(gp[5]),
        .group_mgmt_irq_n(gn), .mgmt_irq_out_pin(opin), .mgmt_irq_out_oe(oe), .serial_irq_group(sg),
        .power_event_logic(pe), .irq(irq));
    mir_host_model u_mir_host_model (.pin(opin), .oe(oe), .pin_level(pin_lvl));
    initial begin
        forever #5 pclk = ~pclk;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d, checks %0d", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // every transfer leaves its expected answer in the queue for the watcher
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
        int i;
        @(posedge pclk);
        q.push_back({e[8], 24'h0, e[7:0]});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {hi, a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // pready is read right at the rising edge, before this edge's updates land
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            bad_count++;
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 9'h000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, {1'b0, e});
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            chk({pslverr, prdata}, q.pop_front());
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 8'h16; k <= 8'h1d; k++) rd(8'(k), 8'h00);
        for (int k = 8'h16; k <= 8'h1d; k++) wr(8'(k), 8'hff);
        rd(8'h16, 8'h3e);
        rd(8'h17, 8'hf7);
        rd(8'h18, 8'hf7);
        rd(8'h19, 8'hff);
        rd(8'h1a, 8'hcf);
        rd(8'h1b, 8'h00);
        rd(8'h1d, 8'h00);
        xfer(1'b0, 8'h20, 8'h00, 9'h100);
        // an aliased high address answers with an error and leaves the register alone
        hi = 2'b01;
        xfer(1'b1, 8'h16, 8'h00, 9'h100);
        hi = 2'b00;
        rd(8'h16, 8'h3e);
        repeat (6) begin
            r = rnd();
            x = rnd();
            wr(8'h16, r[7:0]);
            wr(8'h17, r[15:8]);
            wr(8'h18, r[23:16]);
            wr(8'h19, r[31:24]);
            wr(8'h1a, x[7:0]);
            src <= {r[5:0], x[31:8]};
            rd(8'h12, x[23:16] & 8'hf7);
            rd(8'h13, x[31:24]);
            rd(8'h14, {r[5:4], 2'b00, r[3:0]});
            pend = |({x[12:8], 1'b0} & r[7:0] & 8'h3e) | |({3'b000, x[15], 2'b00, x[14:13]} & r[15:8] & 8'h13)
                | |(x[23:16] & r[23:16] & 8'hf7) | |(x[31:24] & r[31:24]) | |({r[5:4], 2'b00, r[3:0]} & x[7:0]);
            @(negedge pclk);
            chk(gn, !pend);
            chk(sg, pend & r[14]);
            chk(pe, pend & r[13]);
            chk(pin_lvl, !(pend & r[15]));
            @(posedge pclk);
            src <= 30'h0;
            wr(8'h12, 8'hff);
            wr(8'h13, 8'hff);
            wr(8'h14, 8'hff);
            rd(8'h13, 8'h00);
            @(negedge pclk);
            chk(gn, 1'b1);
        end
        wr(8'h31, 8'hff);
        wr(8'h32, 8'hff);
        rd(8'h32, 8'h07);
        for (int k = 0; k < 6; k++) begin
            @(posedge pclk);
            gp <= gp ^ 6'(1 << k);
            wr(8'h1c, 8'h00);
            rd(8'h1c, 8'(1 << k));
            rd(8'h30, 8'h02);
            @(negedge pclk);
            chk(irq, 1'b1);
            wr(8'h1c, 8'(1 << k));
            rd(8'h1c, 8'h00);
            wr(8'h31, 8'h02);
            @(negedge pclk);
            chk(irq, 1'b0);
        end
        wr(8'h32, 8'h05);
        gp <= gp ^ 6'h01;
        rd(8'h30, 8'h02);
        rd(8'h1c, 8'h01);
        @(negedge pclk);
        chk(irq, 1'b0);
        wr(8'h17, 8'h00);
        wr(8'h31, 8'hff);
        ir <= 1'b1;
        rd(8'h11, 8'h04);
        rd(8'h11, 8'h00);
        rd(8'h30, 8'h04);
        // mid-run reset with infrared and gp[5:1] held high: nothing may look like an edge afterwards
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h1c, 8'h00);
        rd(8'h30, 8'h00);
        rd(8'h17, 8'h00);
        @(negedge pclk);
        chk(gn, 1'b1);
        chk(pin_lvl, 1'b1);
        chk(irq, 1'b0);
        repeat (2) @(posedge pclk);
        chk(33'(q.size()), 33'h0);
        test_done();
    end
endmodule // mir_top_test
`default_nettype wire
